// ### design/ee_params.svh
/*
  Constants of the two-wire EEPROM client: bus codes, field widths,
  reset values and the write cycle length.
  Assumes it is included by the package and the top module only.
*/
`ifndef EE_PARAMS_SVH
`define EE_PARAMS_SVH

`define EE_DEV_CODE    4'hA
`define EE_ADDR_W      12
`define EE_PAGE_W      5
`define EE_PAGE_BYTES  32
`define EE_HI_W        4
`define EE_TMR_W       16
`define EE_ACK_BIT     4'h8
`define EE_END_BIT     4'h9
`define EE_PTR_RESET   12'h000
// Write cycle length in clock cycles; plain default, must cover one page
`define EE_WR_CYCLES   1000

`endif

// ### design/ee_pkg.sv
/*
  Types of the two-wire EEPROM client: protocol states and the packed
  state record. Assumes ee_params.svh is on the include path.
*/
package ee_pkg;
  `include "ee_params.svh"

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CTRL = 7'h02,
    ST_ADRH = 7'h04,
    ST_ADRL = 7'h08,
    ST_WDAT = 7'h10,
    ST_RDAT = 7'h20,
    ST_WAIT = 7'h40
  } ee_state_e;

  typedef struct packed {
    logic                    scl_m;
    logic                    scl_s;
    logic                    scl_p;
    logic                    sda_m;
    logic                    sda_s;
    logic                    sda_p;
    logic                    wp_m;
    logic                    wp_s;
    logic [2:0]              cs_m;
    logic [2:0]              cs_s;
    ee_state_e               st;
    logic [3:0]              cnt;
    logic [7:0]              sr;
    logic [`EE_HI_W-1:0]     hi;
    logic [`EE_ADDR_W-1:0]   ptr;
    logic [7:0]              tx;
    logic                    oe;
    logic                    wr_pend;
    logic [`EE_PAGE_BYTES-1:0] mask;
    logic                    busy;
    logic [`EE_TMR_W-1:0]    tmr;
    logic [`EE_ADDR_W-`EE_PAGE_W-1:0] pg;
  } ee_state_s;
endpackage

// ### design/ee_client.sv
/*
  Two-wire serial EEPROM client, 4K x 8 array with a 32-byte page buffer.
  Assumes a host that drives SCL and a pulled-up open-drain SDA wire
  resolved outside; all pins are asynchronous to CLK_I.
*/
`timescale 1ns/1ps
`include "ee_params.svh"

module ee_client
  import ee_pkg::*;
#(
  parameter int unsigned WR_CYCLES = `EE_WR_CYCLES
) (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  input  wire logic SCL_I,
  input  wire logic SDA_I,
  output logic      SDA_O,
  output logic      SDA_OE_O,
  input  wire logic WP_I,
  input  wire logic CHIP_SELECT_BIT0_I,
  input  wire logic CHIP_SELECT_BIT1_I,
  input  wire logic CHIP_SELECT_BIT2_I,
  output logic      BUSY_O
);

  localparam int PAGE = `EE_PAGE_BYTES;
  localparam int DEPTH = 1 << `EE_ADDR_W;

  ee_state_s q_q;
  ee_state_s q_d;
  logic [7:0] mem_q [0:DEPTH-1];
  logic [7:0] pbuf_q [0:PAGE-1];
  logic buf_we;
  logic mem_we;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic ctl_ok;
  logic [`EE_PAGE_W-1:0] widx;
  logic [`EE_ADDR_W-1:0] waddr;
  logic [7:0] wdat;

  // Edges seen on second synchroniser stage only
  assign rise  = q_q.scl_s & ~q_q.scl_p;
  assign fall  = ~q_q.scl_s & q_q.scl_p;
  assign start = q_q.scl_s & q_q.scl_p & q_q.sda_p & ~q_q.sda_s;
  assign stop  = q_q.scl_s & q_q.scl_p & ~q_q.sda_p & q_q.sda_s;
  assign ctl_ok = (q_q.sr[7:4] == `EE_DEV_CODE) && (q_q.sr[3:1] == q_q.cs_s) && !q_q.busy;

  assign widx  = q_q.tmr[`EE_PAGE_W-1:0];
  assign waddr = {q_q.pg, widx};
  // Unwritten bytes are reprogrammed with their old value
  assign wdat  = q_q.mask[widx] ? pbuf_q[widx] : mem_q[waddr];

  // Low bits step and wrap, page bits never move
  function automatic logic [`EE_ADDR_W-1:0] page_step(input logic [`EE_ADDR_W-1:0] a);
    page_step = {a[`EE_ADDR_W-1:`EE_PAGE_W], a[`EE_PAGE_W-1:0] + `EE_PAGE_W'(1)};
  endfunction

  always_comb begin
    q_d = q_q;
    buf_we = 1'b0;
    mem_we = 1'b0;
    q_d.scl_m = SCL_I;
    q_d.scl_s = q_q.scl_m;
    q_d.scl_p = q_q.scl_s;
    q_d.sda_m = SDA_I;
    q_d.sda_s = q_q.sda_m;
    q_d.sda_p = q_q.sda_s;
    q_d.wp_m = WP_I;
    q_d.wp_s = q_q.wp_m;
    q_d.cs_m = {CHIP_SELECT_BIT2_I, CHIP_SELECT_BIT1_I, CHIP_SELECT_BIT0_I};
    q_d.cs_s = q_q.cs_m;
    // Self-timed write: one page byte per cycle, then wait out the rest
    if (q_q.busy) begin
      if (q_q.tmr < `EE_TMR_W'(PAGE)) begin
        mem_we = 1'b1;
      end
      if (q_q.tmr == `EE_TMR_W'(WR_CYCLES - 1)) begin
        q_d.busy = 1'b0;
      end else begin
        q_d.tmr = q_q.tmr + 1'b1;
      end
    end
    if (stop) begin
      q_d.st = ST_IDLE;
      q_d.oe = 1'b0;
      q_d.cnt = 4'h0;
      if (q_q.wr_pend) begin
        q_d.wr_pend = 1'b0;
        q_d.pg = q_q.ptr[`EE_ADDR_W-1:`EE_PAGE_W];
        // Protect level taken here and never again for this cycle
        if (!q_q.wp_s) begin
          q_d.busy = 1'b1;
          q_d.tmr = '0;
        end
      end
    end else if (start) begin
      // Pending write data is dropped, pointer kept
      q_d.st = ST_CTRL;
      q_d.cnt = 4'h0;
      q_d.oe = 1'b0;
      q_d.wr_pend = 1'b0;
    end else begin
      case (q_q.st)
        ST_IDLE, ST_WAIT: begin
          q_d.oe = 1'b0;
        end
        default: begin
          if (rise) begin
            if (q_q.cnt < `EE_ACK_BIT) begin
              q_d.sr = {q_q.sr[6:0], q_q.sda_s};
              q_d.cnt = q_q.cnt + 1'b1;
            end else begin
              q_d.cnt = `EE_END_BIT;
              if (q_q.st == ST_RDAT) begin
                // Pointer wraps naturally at twelve bits
                q_d.ptr = q_q.ptr + 1'b1;
                if (q_q.sda_s) begin
                  q_d.st = ST_WAIT;
                end
              end
            end
          end else if (fall) begin
            if (q_q.cnt == `EE_ACK_BIT) begin
              q_d.oe = 1'b0;
              case (q_q.st)
                ST_CTRL: begin
                  if (ctl_ok) begin
                    q_d.oe = 1'b1;
                    // A read waits here over the ack clock so the pointer holds
                    q_d.st = q_q.sr[0] ? ST_CTRL : ST_ADRH;
                  end else begin
                    q_d.st = ST_WAIT;
                  end
                end
                ST_ADRH: begin
                  q_d.hi = q_q.sr[`EE_HI_W-1:0];
                  q_d.oe = 1'b1;
                  q_d.st = ST_ADRL;
                end
                ST_ADRL: begin
                  q_d.ptr = {q_q.hi, q_q.sr};
                  q_d.mask = '0;
                  q_d.oe = 1'b1;
                  q_d.st = ST_WDAT;
                end
                ST_WDAT: begin
                  // Acknowledged even when protected
                  buf_we = 1'b1;
                  q_d.mask[q_q.ptr[`EE_PAGE_W-1:0]] = 1'b1;
                  q_d.ptr = page_step(q_q.ptr);
                  q_d.wr_pend = 1'b1;
                  q_d.oe = 1'b1;
                end
                default: begin
                  q_d.oe = 1'b0;
                end
              endcase
            end else if (q_q.cnt == `EE_END_BIT) begin
              q_d.cnt = 4'h0;
              q_d.oe = 1'b0;
              if (q_q.st == ST_RDAT || q_q.st == ST_CTRL) begin
                q_d.st = ST_RDAT;
                q_d.tx = mem_q[q_q.ptr];
                q_d.oe = ~mem_q[q_q.ptr][7];
              end
            end else if (q_q.st == ST_RDAT && q_q.cnt != 4'h0) begin
              q_d.oe = ~q_q.tx[3'(4'h7 - q_q.cnt)];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      // Idle-high line copies, so no false edge follows reset
      q_q <= '{st:      ST_IDLE,
               ptr:     `EE_PTR_RESET,
               scl_m:   1'b1,
               scl_s:   1'b1,
               scl_p:   1'b1,
               sda_m:   1'b1,
               sda_s:   1'b1,
               sda_p:   1'b1,
               default: '0};
    end else begin
      q_q <= q_d;
    end
  end

  // Array and page buffer carry no reset, like the cells they model
  always_ff @(posedge CLK_I) begin
    if (buf_we) begin
      pbuf_q[q_q.ptr[`EE_PAGE_W-1:0]] <= q_q.sr;
    end
    if (mem_we) begin
      mem_q[waddr] <= wdat;
    end
  end

  // Open drain: only ever pulls low
  assign SDA_O    = 1'b0;
  assign SDA_OE_O = q_q.oe;
  assign BUSY_O   = q_q.busy;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  sequence s_ctl_byte;
    q_q.st == ST_CTRL && fall && q_q.cnt == `EE_ACK_BIT;
  endsequence

  sequence s_wr_stop;
    stop && q_q.wr_pend;
  endsequence

  a_busy_no_ack: assert property (s_ctl_byte and q_q.busy |=> !q_q.oe)
    else $error("acknowledge given during write cycle");
  a_cs_mismatch: assert property (s_ctl_byte and q_q.sr[3:1] != q_q.cs_s |=> !q_q.oe [*2])
    else $error("acknowledge to foreign chip select");
  a_idle_ack: assert property (s_ctl_byte and ctl_ok |=> q_q.oe)
    else $error("matching control byte not acknowledged");
  a_wp_blocks: assert property (s_wr_stop and q_q.wp_s |=> !q_q.busy)
    else $error("protected write started a cycle");
  a_write_runs: assert property (s_wr_stop and !q_q.wp_s and !q_q.busy |=> q_q.busy [*8])
    else $error("write cycle not started at stop");
  a_page_wrap: assert property (buf_we |=> q_q.ptr[11:5] == $past(q_q.ptr[11:5])
      && q_q.ptr[4:0] == $past(q_q.ptr[4:0]) + 5'h01)
    else $error("page pointer step wrong");
  a_top_wrap: assert property (q_q.st == ST_RDAT && rise && q_q.cnt == `EE_ACK_BIT
      && q_q.ptr == 12'hFFF |=> q_q.ptr == 12'h000)
    else $error("pointer did not roll to zero");
  a_nack_release: assert property (q_q.st == ST_RDAT && rise && q_q.cnt == `EE_ACK_BIT
      && q_q.sda_s |=> q_q.st == ST_WAIT ##1 !q_q.oe)
    else $error("data line held after host nack");
  a_abort_write: assert property (start && !stop |=> !q_q.wr_pend && q_q.ptr == $past(q_q.ptr))
    else $error("repeated start kept pending write");

  sequence s_rd_ack_clk;
    q_q.st == ST_RDAT && rise && q_q.cnt == `EE_ACK_BIT;
  endsequence

  sequence s_rd_first;
    q_q.st == ST_CTRL && fall && q_q.cnt == `EE_END_BIT;
  endsequence

  a_ctl_ptr_hold: assert property (q_q.st == ST_CTRL |=> q_q.ptr == $past(q_q.ptr))
    else $error("pointer moved during control byte");
  a_rd_first: assert property (s_rd_first |=> q_q.st == ST_RDAT && q_q.oe == ~q_q.tx[7])
    else $error("first read bit not presented");
  a_rd_step: assert property (s_rd_ack_clk |=> q_q.ptr == $past(q_q.ptr) + 12'h001)
    else $error("pointer did not step after read byte");
  a_rd_more: assert property (s_rd_ack_clk and !q_q.sda_s |=> q_q.st == ST_RDAT)
    else $error("host acknowledge did not continue read");
  a_busy_len: assert property ($fell(q_q.busy)
      |-> $past(q_q.tmr) == `EE_TMR_W'(WR_CYCLES - 1))
    else $error("write cycle ended early");
  a_cycle_writes: assert property ($rose(q_q.busy) |-> mem_we [*8])
    else $error("write cycle skipped page bytes");
  a_adr_load: assert property (q_q.st == ST_ADRL && fall && q_q.cnt == `EE_ACK_BIT
      |=> q_q.ptr == {$past(q_q.hi), $past(q_q.sr)} && q_q.mask == '0)
    else $error("address bytes not loaded into pointer");
  a_pend_set: assert property (buf_we |=> q_q.wr_pend)
    else $error("buffered byte left no pending write");
  a_stop_idle: assert property (stop |=> q_q.st == ST_IDLE && !q_q.oe)
    else $error("data line held after stop");
  a_wait_quiet: assert property (q_q.st == ST_WAIT |=> !q_q.oe)
    else $error("ignored transfer pulled the data line");
  a_code_refuse: assert property (s_ctl_byte and q_q.sr[7:4] != `EE_DEV_CODE
      |=> !q_q.oe [*2])
    else $error("acknowledge to foreign device code");

endmodule

// ### verif/ee_host.sv
/*
  Bus host model: Start, Stop and byte tasks on SCL and open-drain SDA.
  Assumes the bench resolves SDA with a pull-up and calls the tasks.
*/
`timescale 1ns/1ps

module ee_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // SCL stands high between frames
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // Five clocks a quarter, 160 ns per SCL period
  task automatic tick();
    repeat (5) @(posedge clk_i);
    #1;
  endtask

  task automatic start();
    sda_low_o = 1'b0;
    tick();
    scl_o = 1'b1;
    tick();
    sda_low_o = 1'b1;
    tick();
    scl_o = 1'b0;
    tick();
  endtask

  task automatic stop();
    sda_low_o = 1'b1;
    tick();
    scl_o = 1'b1;
    tick();
    sda_low_o = 1'b0;
    tick();
  endtask

  // Sampled mid-high, well after the client's answer settles
  task automatic bit_io(input logic b, output logic s);
    sda_low_o = ~b;
    tick();
    scl_o = 1'b1;
    tick();
    s = sda_i;
    tick();
    scl_o = 1'b0;
    tick();
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule

// ### verif/tb_i2c_eeprom_client_access.sv
/*
  Self-checking bench of the EEPROM client with a host model.
  Assumes a short write cycle parameter and a pulled-up SDA wire.
*/
`timescale 1ns/1ps

module tb_i2c_eeprom_client_access;
  import ee_pkg::*;
  localparam logic [2:0] CS = 3'h5;
  typedef struct packed { logic [11:0] a; logic [7:0] d; } ee_row_s;
  ee_row_s     rows [4] = '{'{12'h123, 8'h5A}, '{12'h124, 8'hA5},
                            '{12'hFFF, 8'h77}, '{12'h000, 8'h11}};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wp = 1'b0;
  logic [2:0]  cs_pins = CS;
  logic        scl, sda_low, sda, oe, sdo, busy;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;

  // Pull-up: high unless someone pulls low
  assign sda = ~(sda_low | (oe & ~sdo));

  ee_client #(.WR_CYCLES(400)) ee_client_inst (.CLK_I(clk), .RST_I(rst), .SCL_I(scl),
    .SDA_I(sda), .SDA_O(sdo), .SDA_OE_O(oe), .WP_I(wp), .CHIP_SELECT_BIT0_I(cs_pins[0]),
    .CHIP_SELECT_BIT1_I(cs_pins[1]), .CHIP_SELECT_BIT2_I(cs_pins[2]), .BUSY_O(busy));
  ee_host ee_host_inst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  initial begin
    forever #4 clk = ~clk;
  end

  // Ceiling well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic ctl(input logic [3:0] code, input logic rw, output logic ack);
    ee_host_inst.start();
    ee_host_inst.wbyte({code, CS, rw}, ack);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input int n);
    logic ack;
    ctl(4'hA, 1'b0, ack);
    chk("ctl ack", ack, 1'b1);
    ee_host_inst.wbyte({4'hF, a[11:8]}, ack);
    chk("adh ack", ack, 1'b1);
    ee_host_inst.wbyte(a[7:0], ack);
    chk("adl ack", ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      ee_host_inst.wbyte(d + 8'(i), ack);
      chk("dat ack", ack, 1'b1);
    end
    ee_host_inst.stop();
  endtask

  task automatic poll(output int nacks);
    logic ack;
    nacks = 0;
    ack = 1'b0;
    while (!ack && nacks < 20) begin
      ctl(4'hA, 1'b0, ack);
      ee_host_inst.stop();
      if (!ack) nacks++;
    end
  endtask

  task automatic cur(input logic two, output logic [15:0] dd);
    logic ack;
    ctl(4'hA, 1'b1, ack);
    chk("rd ack", ack, 1'b1);
    ee_host_inst.rbyte(two, dd[15:8]);
    if (two) ee_host_inst.rbyte(1'b0, dd[7:0]);
    ee_host_inst.stop();
  endtask

  task automatic rd(input logic [11:0] a, input logic two, output logic [15:0] dd);
    logic ack;
    ctl(4'hA, 1'b0, ack);
    ee_host_inst.wbyte({4'h0, a[11:8]}, ack);
    ee_host_inst.wbyte(a[7:0], ack);
    cur(two, dd);
  endtask

  initial begin
    int          n;
    logic [15:0] dd;
    logic        ack;
    repeat (12) @(posedge clk);
    #1;
    chk("oe rst", oe, 1'b0);
    chk("busy rst", busy, 1'b0);
    rst = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, 1);
      chk("busy set", 8'(busy), 8'h01);
      poll(n);
      chk("busy nack", 8'(n > 0), 8'h01);
      rd(rows[i].a, 1'b0, dd);
      chk("rd data", dd[15:8], rows[i].d);
    end
    rd(12'hFFF, 1'b1, dd);
    chk("roll", dd[7:0], 8'h11);
    chk("top", dd[15:8], 8'h77);
    wr(12'h122, 8'h3C, 1);
    poll(n);
    cur(1'b0, dd);
    chk("next wr", dd[15:8], 8'h5A);
    cur(1'b0, dd);
    chk("next rd", dd[15:8], 8'hA5);
    wr(12'h01E, 8'h40, 3);
    poll(n);
    rd(12'h01E, 1'b1, dd);
    chk("page first", dd[15:8], 8'h40);
    chk("page next", dd[7:0], 8'h41);
    rd(12'h000, 1'b0, dd);
    chk("wrap", dd[15:8], 8'h42);
    wr(12'h0C0, 8'h60, 33);
    poll(n);
    rd(12'h0C0, 1'b1, dd);
    chk("overrun first", dd[15:8], 8'h80);
    chk("overrun next", dd[7:0], 8'h61);
    wp = 1'b1;
    wr(12'h123, 8'hEE, 1);
    chk("wp idle", 8'(busy), 8'h00);
    poll(n);
    chk("wp nack", 8'(n), 8'h00);
    wp = 1'b0;
    rd(12'h123, 1'b0, dd);
    chk("wp data", dd[15:8], 8'h5A);
    wr(12'h124, 8'h99, 1);
    wp = 1'b1;
    poll(n);
    wp = 1'b0;
    rd(12'h124, 1'b0, dd);
    chk("wp late", dd[15:8], 8'h99);
    cs_pins = 3'h2;
    ctl(4'hA, 1'b0, ack);
    ee_host_inst.stop();
    chk("cs nack", ack, 1'b0);
    cs_pins = CS;
    ctl(4'h5, 1'b0, ack);
    ee_host_inst.stop();
    chk("code nack", ack, 1'b0);
    close_out();
  end
endmodule
